// ==== hw/clid_pkg.sv ====
// Package of constants and types for the character display instruction decoder.
package clid_pkg;
  localparam int DATA_W = 8;
  localparam int AC_W   = 7;
  localparam int CG_W   = 6;
  localparam int TEXT_DEPTH  = 128;
  localparam int GLYPH_DEPTH = 64;

  // Instruction field positions.
  localparam int BIT_DDADDR = 7;
  localparam int BIT_CGADDR = 6;
  localparam int BIT_FUNC   = 5;
  localparam int BIT_SHIFT  = 4;
  localparam int BIT_ENTRY  = 2;
  localparam int BIT_DL     = 4;
  localparam int BIT_N      = 3;
  localparam int BIT_F      = 2;
  localparam int BIT_SC     = 3;
  localparam int BIT_RL     = 2;
  localparam int BIT_ID     = 1;
  localparam int BIT_SH     = 0;

  // Text memory address map.
  localparam logic [6:0] ONE_LINE_LAST  = 7'h4f;
  localparam logic [6:0] LINE1_LAST     = 7'h27;
  localparam logic [6:0] LINE2_FIRST    = 7'h40;
  localparam logic [6:0] LINE2_LAST     = 7'h67;
  localparam logic [6:0] ADDR_ZERO      = 7'h00;

  // Execution time per accepted access, in cycles of the 25 MHz clock.
  localparam int EXEC_CYCLES = 4;
  // The busy counter is eight bits wide, so longer executions cannot be counted.
  localparam int EXEC_MAX    = 255;

  typedef enum logic [1:0] {
    CLID_IDLE = 2'b00,
    CLID_EXEC = 2'b01
  } clid_state_e;

  typedef struct packed {
    logic busWidth8;
    logic twoLine;
    logic tallFont;
    logic stepUp;
    logic autoShiftEnable;
    logic glyphSel;
  } clid_mode_s;
endpackage

// ==== hw/clid_decoder.sv ====
// Instruction decoder and memory of the character display controller.
//
// Behaviour
// [R01] Cursor left shift decrements address counter.
// [R02] Cursor right shift increments address counter.
// [R03] Display shift moves whole display, cursor follows.
// [R04] Function set bit four selects bus width.
// [R05] Four-bit mode pairs two nibbles per byte.
// [R06] Function set bit three selects line count.
// [R07] Function set bit two selects font height.
// [R08] Glyph address set loads six bits.
// [R09] Text address set loads seven bits.
// [R10] Single line text addresses span 00 to 4F.
// [R11] Two lines span 00-27 and 40-67.
// [R12] Status read returns busy and address counter.
// [R13] Host waits while busy reads high.
// [R14] Data write stores into selected memory.
// [R15] Data write steps address counter by one.
// [R16] First read without address set is invalid.
// [R17] Cursor shift preloads text read register.
// [R18] Data read steps address counter by one.
// [R19] Glyph read may spoil next display shift.
// [R20] Read after write returns previously latched data.
// [R21] Step direction high increments, low decrements.
// [R22] Shift instruction code; display shift keeps counter.
// [R23] Busy held from acceptance until execution ends.
// [R24] Reset gives eight-bit bus, counter zero.
`timescale 1ns/1ps
module clid_decoder
  import clid_pkg::*;
#(
  parameter int ExecCycles = EXEC_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              strobe,
  input  wire logic              register_select,
  input  wire logic              readNotWrite,
  input  wire logic [DATA_W-1:0] busIn,
  output logic      [DATA_W-1:0] busOut,
  output logic                   busOutValid,
  output logic                   internal_busy_indicator,
  output logic      [AC_W-1:0]   addr_counter,
  output clid_mode_s             mode,
  output logic      [6:0]        displayShift
);

  // Elaboration checks. The counter width and the memory sizes are tied together,
  // so a mismatched package would silently alias addresses.
  initial begin
    if (ExecCycles < 1 || ExecCycles > EXEC_MAX) begin
      $error("ExecCycles out of range");
    end
    if (DATA_W != 8) begin
      $error("DATA_W must be 8");
    end
    if (AC_W != 7) begin
      $error("AC_W must be 7");
    end
    if (CG_W >= AC_W) begin
      $error("CG_W must be narrower than AC_W");
    end
    if (TEXT_DEPTH != (1 << AC_W)) begin
      $error("TEXT_DEPTH must match AC_W");
    end
    if (GLYPH_DEPTH != (1 << CG_W)) begin
      $error("GLYPH_DEPTH must match CG_W");
    end
  end

  logic [DATA_W-1:0] textMem  [TEXT_DEPTH];
  logic [DATA_W-1:0] glyphMem [GLYPH_DEPTH];

  logic              nibbleHalf_reg;
  logic [3:0]        nibbleHigh_reg;
  logic [7:0]        execCnt_reg;
  clid_state_e       state_reg;
  logic [DATA_W-1:0] readLatch_reg;
  logic              glyphReadLast_reg;

  // A byte is complete on every strobe in 8-bit mode, or on the second nibble. [R05]
  logic              byteDone;
  logic [DATA_W-1:0] byteVal;
  logic              accept;
  always_comb begin
    byteDone = strobe && (mode.busWidth8 || nibbleHalf_reg);
    byteVal  = mode.busWidth8 ? busIn : {nibbleHigh_reg, busIn[7:4]};
  end
  // Status reads are allowed while busy; other accesses are taken only when idle.
  always_comb begin
    accept = byteDone && (state_reg == CLID_IDLE)
             && !(!register_select && readNotWrite);
  end

  // The nibble phase toggles on every strobe in 4-bit mode, even on a refused
  // access. The host must therefore always send whole pairs, or the halves of
  // every later byte are swapped until reset or a return to 8-bit mode.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nibbleHalf_reg <= 1'b0;
      nibbleHigh_reg <= 4'h0;
    end else if (strobe && !mode.busWidth8) begin
      nibbleHalf_reg <= !nibbleHalf_reg; // [R05]
      nibbleHigh_reg <= busIn[7:4];
    end else if (mode.busWidth8) begin
      nibbleHalf_reg <= 1'b0;
    end
  end

  // Instruction classes.
  logic isInstr;
  logic isData;
  logic insDd;
  logic insCg;
  logic insFunc;
  logic insShift;
  logic insEntry;
  always_comb begin
    isInstr  = accept && !register_select && !readNotWrite;
    isData   = accept && register_select;
    insDd    = 1'b0;
    insCg    = 1'b0;
    insFunc  = 1'b0;
    insShift = 1'b0;
    insEntry = 1'b0;
    // The leading set bit of an instruction byte names its class. The display
    // on/off class is recognised only so that it cannot fall into entry mode.
    if (isInstr) begin
      case (1'b1)
        byteVal[BIT_DDADDR]: insDd    = 1'b1; // [R09]
        byteVal[BIT_CGADDR]: insCg    = 1'b1; // [R08]
        byteVal[BIT_FUNC]:   insFunc  = 1'b1; // [R04]
        byteVal[BIT_SHIFT]:  insShift = 1'b1; // [R22]
        byteVal[BIT_SC]:     insEntry = 1'b0;
        byteVal[BIT_ENTRY]:  insEntry = 1'b1;
        default:             insEntry = 1'b0;
      endcase
    end
  end

  // Address counter wraps inside the legal text ranges of the current line mode.
  function automatic logic [6:0] textStep(input logic [6:0] a, input logic up,
                                          input logic two);
    logic [6:0] r;
    r = a;
    if (!two) begin
      if (up) begin
        r = (a >= ONE_LINE_LAST) ? ADDR_ZERO : 7'(a + 7'h01); // [R10]
      end else begin
        r = (a == ADDR_ZERO) ? ONE_LINE_LAST : 7'(a - 7'h01);
      end
    end else begin
      if (up) begin
        if (a == LINE1_LAST)      r = LINE2_FIRST; // [R11]
        else if (a >= LINE2_LAST) r = ADDR_ZERO;
        else                      r = 7'(a + 7'h01);
      end else begin
        if (a == LINE2_FIRST)     r = LINE1_LAST;
        else if (a == ADDR_ZERO)  r = LINE2_LAST;
        else                      r = 7'(a - 7'h01);
      end
    end
    return r;
  endfunction

  function automatic logic [6:0] acStep(input logic [6:0] a, input logic up,
                                        input logic glyph, input logic two);
    logic [CG_W-1:0] g;
    logic [6:0]      r;
    // Glyph addresses wrap at their own width; text addresses follow the line map.
    g = up ? CG_W'(a[CG_W-1:0] + 1'b1) : CG_W'(a[CG_W-1:0] - 1'b1);
    if (glyph) begin
      r = 7'(g);
    end else begin
      r = textStep(a, up, two);
    end
    return r;
  endfunction

  // Address counter concern. Address loads win over stepping, as only one
  // instruction or data access can be taken in any cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_counter <= ADDR_ZERO; // [R24]
    end else if (insDd) begin
      addr_counter <= byteVal[AC_W-1:0]; // [R09]
    end else if (insCg) begin
      addr_counter <= {1'b0, byteVal[CG_W-1:0]}; // [R08]
    end else if (insShift && !byteVal[BIT_SC]) begin
      // Cursor shift: low R/L decrements, high increments.
      addr_counter <= acStep(addr_counter, byteVal[BIT_RL], mode.glyphSel,
                             mode.twoLine); // [R01] [R02]
    end else if (isData) begin
      addr_counter <= acStep(addr_counter, mode.stepUp, mode.glyphSel,
                             mode.twoLine); // [R15] [R18] [R21]
    end
  end

  // Mode concern.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode.busWidth8       <= 1'b1; // [R24]
      mode.twoLine         <= 1'b0;
      mode.tallFont        <= 1'b0;
      mode.stepUp          <= 1'b1;
      mode.autoShiftEnable <= 1'b0;
      mode.glyphSel        <= 1'b0;
    end else begin
      if (insFunc) begin
        mode.busWidth8 <= byteVal[BIT_DL]; // [R04]
        mode.twoLine   <= byteVal[BIT_N];  // [R06]
        mode.tallFont  <= byteVal[BIT_F];  // [R07]
      end
      if (insEntry) begin
        mode.stepUp          <= byteVal[BIT_ID];
        mode.autoShiftEnable <= byteVal[BIT_SH];
      end
      if (insDd) mode.glyphSel <= 1'b0; // [R09]
      if (insCg) mode.glyphSel <= 1'b1; // [R08]
    end
  end

  // Display shift offset; a display shift never touches the counter or memory.
  // A display shift right after a glyph read is suppressed, as its result
  // cannot be relied upon.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      displayShift <= 7'h00;
    end else if (insShift && byteVal[BIT_SC] && !glyphReadLast_reg) begin // [R19]
      displayShift <= byteVal[BIT_RL] ? 7'(displayShift + 7'h01)
                                      : 7'(displayShift - 7'h01); // [R03] [R22]
    end else if (isData && !readNotWrite && !mode.glyphSel && mode.autoShiftEnable) begin
      displayShift <= mode.stepUp ? 7'(displayShift - 7'h01)
                                  : 7'(displayShift + 7'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      glyphReadLast_reg <= 1'b0;
    end else if (isData || isInstr) begin
      glyphReadLast_reg <= isData && readNotWrite && mode.glyphSel; // [R19]
    end
  end

  // Memory writes. The arrays have no reset, so their contents stay unknown
  // until the host has written them.
  always_ff @(posedge clk) begin
    if (isData && !readNotWrite) begin
      if (mode.glyphSel) glyphMem[addr_counter[CG_W-1:0]] <= byteVal; // [R14]
      else               textMem[addr_counter] <= byteVal; // [R14]
    end
  end

  // Next-address prefetch used by reads and cursor shifts. Reading ahead keeps
  // the latch a plain register, at the cost that a read after a write is stale.
  logic [AC_W-1:0] readNextAddr;
  logic [AC_W-1:0] cursorNextAddr;
  logic [CG_W-1:0] glyphNextAddr;
  always_comb begin
    readNextAddr   = acStep(addr_counter, mode.stepUp, 1'b0, mode.twoLine);
    cursorNextAddr = acStep(addr_counter, byteVal[BIT_RL], 1'b0, mode.twoLine);
    glyphNextAddr  = CG_W'(acStep(addr_counter, mode.stepUp, 1'b1, mode.twoLine));
  end

  // The output data register is only refreshed by address set, cursor shift
  // or a read. A read returns what was latched earlier, so the first read
  // after a write or without an address set is stale.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readLatch_reg <= 8'h00;
    end else if (insDd) begin
      readLatch_reg <= textMem[byteVal[AC_W-1:0]]; // [R09]
    end else if (insCg) begin
      readLatch_reg <= glyphMem[byteVal[CG_W-1:0]];
    end else if (insShift && !byteVal[BIT_SC] && !mode.glyphSel) begin
      readLatch_reg <= textMem[cursorNextAddr]; // [R17]
    end else if (isData && readNotWrite) begin
      readLatch_reg <= mode.glyphSel ? glyphMem[glyphNextAddr]
                                     : textMem[readNextAddr]; // [R16] [R20]
    end
  end

  // Status word seen by a status read. It holds the values from before this
  // edge, so a status read never shows the effect of its own cycle.
  logic [DATA_W-1:0] statusWord;
  always_comb begin
    statusWord = {internal_busy_indicator, addr_counter}; // [R12]
  end

  // Read port. Status reads are answered even while busy, so the host can
  // always poll; data reads are answered only when they are accepted.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busOut      <= 8'h00;
      busOutValid <= 1'b0;
    end else if (byteDone && readNotWrite && !register_select) begin
      busOut      <= statusWord; // [R12]
      busOutValid <= 1'b1;
    end else if (accept && readNotWrite) begin
      busOut      <= readLatch_reg; // [R16] [R20]
      busOutValid <= 1'b1;
    end else begin
      busOutValid <= 1'b0;
    end
  end

  // Busy concern. The busy level is a register set and cleared with the state, so it can never disagree
  // with what the accept logic refuses. An access offered in the very cycle
  // in which busy falls is still refused; the host must see busy low first.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg               <= CLID_IDLE;
      execCnt_reg             <= 8'h00;
      internal_busy_indicator <= 1'b0;
    end else if (state_reg == CLID_IDLE) begin
      if (accept) begin
        state_reg               <= CLID_EXEC;
        execCnt_reg             <= 8'(ExecCycles - 1);
        internal_busy_indicator <= 1'b1; // [R23]
      end
    end else if (execCnt_reg == 8'h00) begin
      state_reg               <= CLID_IDLE;
      internal_busy_indicator <= 1'b0; // [R23] [R13]
    end else begin
      execCnt_reg <= 8'(execCnt_reg - 8'h01);
    end
  end

endmodule

// ==== sim/clid_checker.sv ====
// Port assertions for the character display instruction decoder.
`timescale 1ns/1ps
module clid_checker
  import clid_pkg::*;
#(
  parameter int ExecCycles = EXEC_CYCLES
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        strobe,
  input wire logic        register_select,
  input wire logic        readNotWrite,
  input wire logic [7:0]  busIn,
  input wire logic [7:0]  busOut,
  input wire logic        busOutValid,
  input wire logic        internal_busy_indicator,
  input wire logic [6:0]  addr_counter,
  input wire clid_mode_s  mode,
  input wire logic [6:0]  displayShift
);
  // Only whole bytes in 8-bit mode are judged; nibble phase is not visible at the ports.
  wire acc = strobe && mode.busWidth8 && !internal_busy_indicator
             && (register_select || !readNotWrite);
  wire ins = acc && !register_select;
  wire midLine = !mode.twoLine && !mode.glyphSel && addr_counter != 7'h00
                 && addr_counter < 7'h4f;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_status_read: assert property (strobe && mode.busWidth8 && !register_select && readNotWrite
    |=> busOutValid && busOut == {$past(internal_busy_indicator), $past(addr_counter)})
    else $error("status read value wrong");
  a_busy_hold: assert property (acc |=> internal_busy_indicator [*4] ##1 !internal_busy_indicator)
    else $error("busy span wrong");
  a_cursor_left: assert property (ins && busIn[7:2] == 6'b000100 && midLine
    |=> addr_counter == $past(addr_counter) - 7'h01) else $error("cursor left wrong");
  a_cursor_right: assert property (ins && busIn[7:2] == 6'b000101 && midLine
    |=> addr_counter == $past(addr_counter) + 7'h01) else $error("cursor right wrong");
  a_dshift_keep: assert property (ins && busIn[7:3] == 5'b00011 |=> $stable(addr_counter))
    else $error("display shift moved counter");
  a_text_addr: assert property (ins && busIn[7]
    |=> addr_counter == $past(busIn[6:0]) && !mode.glyphSel) else $error("text address wrong");
  a_glyph_addr: assert property (ins && busIn[7:6] == 2'b01
    |=> addr_counter == {1'b0, $past(busIn[5:0])} && mode.glyphSel)
    else $error("glyph address wrong");
  a_func_set: assert property (ins && busIn[7:5] == 3'b001
    |=> {mode.busWidth8, mode.twoLine, mode.tallFont} == $past(busIn[4:2]))
    else $error("function set wrong");
  cover property (ins && busIn[7]);
  cover property (strobe && internal_busy_indicator && register_select);
  cover property (acc && register_select && readNotWrite);
endmodule

bind clid_decoder clid_checker #(.ExecCycles(ExecCycles)) u_clid_checker (.clk, .rst_n,
  .strobe, .register_select, .readNotWrite, .busIn, .busOut, .busOutValid,
  .internal_busy_indicator, .addr_counter, .mode, .displayShift);

// ==== sim/clid_host.sv ====
// Host processor model for the parallel port of the decoder.
`timescale 1ns/1ps
module clid_host (
  input  wire logic       clk,
  input  wire logic [7:0] busOut,
  output logic            strobe,
  output logic            register_select,
  output logic            readNotWrite,
  output logic [7:0]      busIn
);
  logic wide = 1'b1;
  initial begin
    strobe = 1'b0;
    register_select = 1'b0;
    readNotWrite = 1'b0;
    busIn = 8'h00;
  end
  task automatic nib(input logic rs, input logic rnw, input logic [7:0] d);
    @(negedge clk);
    strobe = 1'b1;
    register_select = rs;
    readNotWrite = rnw;
    busIn = d;
    @(negedge clk);
    strobe = 1'b0;
    // A released bus must not keep showing the last byte.
    busIn = ~d;
  endtask
  task automatic put(input logic rs, input logic rnw, input logic [7:0] d, output logic [7:0] q);
    if (wide) begin
      nib(rs, rnw, d);
    end else begin
      nib(rs, rnw, {d[7:4], ~d[3:0]});
      nib(rs, rnw, {d[3:0], ~d[3:0]});
    end
    @(negedge clk);
    q = busOut;
    if (!rs && !rnw && d[7:5] == 3'b001) begin
      wide = d[4];
    end
  endtask
  task automatic poll();
    logic [7:0] s;
    s = 8'h80;
    for (int n = 0; n < 40 && s[7] !== 1'b0; n++) begin
      put(1'b0, 1'b1, 8'h00, s);
    end
  endtask
endmodule

// ==== sim/clid_decoder_tb.sv ====
// Self-checking bench for the character display instruction decoder.
`timescale 1ns/1ps
module clid_decoder_tb
  import clid_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  wire         strobe, register_select, readNotWrite;
  wire  [7:0]  busIn;
  logic [7:0]  busOut, q, d, r;
  logic        busOutValid, internal_busy_indicator;
  logic [6:0]  addr_counter, displayShift, a, eac, eds;
  clid_mode_s  mode;
  logic [31:0] seed = 32'd24;
  int          nMismatch = 0;
  int          nCompared = 0;
  clid_decoder #(.ExecCycles(4)) u_clid_decoder (.clk, .rst_n, .strobe, .register_select,
    .readNotWrite, .busIn, .busOut, .busOutValid, .internal_busy_indicator, .addr_counter,
    .mode, .displayShift);
  clid_host u_clid_host (.clk, .busOut, .strobe, .register_select, .readNotWrite, .busIn);
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [7:0] nextRnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [6:0] stepAddr(input logic [6:0] x, input logic up);
    return up ? x + 7'h01 : x - 7'h01;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic endSim();
    $display("compared=%0d mismatches=%0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmd(input logic rs, input logic rnw, input logic [7:0] v);
    u_clid_host.put(rs, rnw, v, q);
    u_clid_host.poll();
  endtask
  initial begin
    #2000000;
    nMismatch++;
    endSim();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk({mode.busWidth8, addr_counter}, 8'h80);
    for (int i = 0; i < 8; i++) begin
      cmd(1'b0, 1'b0, {3'b001, i[2:0], 2'b00});
      chk({5'h0, mode.busWidth8, mode.twoLine, mode.tallFont}, {5'h0, i[2:0]});
    end
    cmd(1'b0, 1'b0, 8'h30);
    repeat (6) begin
      r = nextRnd();
      a = {1'b0, r[5:0]};
      d = nextRnd();
      cmd(1'b0, 1'b0, {1'b1, a});
      cmd(1'b1, 1'b0, d);
      chk({1'b0, addr_counter}, {1'b0, a + 7'h01});
      cmd(1'b0, 1'b0, {1'b1, a});
      cmd(1'b1, 1'b1, 8'h00);
      chk(q, d);
      chk({1'b0, addr_counter}, {1'b0, a + 7'h01});
      cmd(1'b0, 1'b0, {1'b1, a});
      cmd(1'b1, 1'b0, ~d);
      cmd(1'b1, 1'b1, 8'h00);
      chk(q, d);
    end
    cmd(1'b0, 1'b0, 8'h90);
    eac = 7'h10;
    eds = 7'h00;
    for (int k = 0; k < 4; k++) begin
      cmd(1'b0, 1'b0, {4'b0001, k[1:0], 2'b00});
      if (!k[1]) eac = stepAddr(eac, k[0]);
      else eds = stepAddr(eds, k[0]);
      chk({1'b0, addr_counter}, {1'b0, eac});
      chk({1'b0, displayShift}, {1'b0, eds});
    end
    cmd(1'b0, 1'b0, 8'h04);
    cmd(1'b0, 1'b0, 8'ha0);
    cmd(1'b1, 1'b0, nextRnd());
    chk({1'b0, addr_counter}, {1'b0, stepAddr(7'h20, 1'b0)});
    cmd(1'b0, 1'b0, 8'h06);
    r = nextRnd();
    d = nextRnd();
    cmd(1'b0, 1'b0, {2'b01, r[5:0]});
    chk({mode.glyphSel, addr_counter}, {2'b10, r[5:0]});
    cmd(1'b1, 1'b0, d);
    cmd(1'b0, 1'b0, {2'b01, r[5:0]});
    cmd(1'b1, 1'b1, 8'h00);
    chk(q, d);
    cmd(1'b0, 1'b0, 8'h90);
    u_clid_host.put(1'b1, 1'b0, 8'h55, q);
    chk({7'h0, internal_busy_indicator}, 8'h01);
    // Sent while busy on purpose: the second byte must leave no trace.
    u_clid_host.put(1'b1, 1'b0, 8'h66, q);
    u_clid_host.poll();
    u_clid_host.put(1'b0, 1'b1, 8'h00, q);
    chk(q, 8'h11);
    endSim();
  end
endmodule
